// ===== hdl/sbs_defs.svh
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// ---------------------------------------------------------------
// Array geometry
// ---------------------------------------------------------------
`define SBS_ADDR_W      17
`define SBS_LANES       4
`define SBS_BYTE_W      8
`define SBS_LANE_W      9
`define SBS_FIFO_DEPTH  16

// ---------------------------------------------------------------
// Burst counter and lane mask
// ---------------------------------------------------------------
`define SBS_CNT_LAST    2'h3
`define SBS_ALL_LANES   4'hf

// ---------------------------------------------------------------
// Pin synchroniser slots and their reset levels
// ---------------------------------------------------------------
`define SBS_PIN_N       5
`define SBS_PIN_TCK     0
`define SBS_PIN_TMS     1
`define SBS_PIN_TDI     2
`define SBS_PIN_TRST    3
`define SBS_PIN_SLEEP   4
`define SBS_PIN_RST     5'h0a

// ---------------------------------------------------------------
// Test port instructions
// ---------------------------------------------------------------
`define SBS_IR_W        4
`define SBS_IR_CAPTURE  4'h1
`define SBS_IR_IDCODE   4'h2
`define SBS_IR_BYPASS   4'hf
`define SBS_DR_W        32
// The identification value is arbitrary.
`define SBS_IDCODE      32'h0a5a_5001

`endif

// ===== hdl/sbs_pkg.sv
package sbs_pkg;

    // ---------------------------------------------------------------
    // Test controller states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET   = 4'b0000,
        TAP_IDLE    = 4'b0001,
        TAP_SEL_DR  = 4'b0010,
        TAP_CAP_DR  = 4'b0011,
        TAP_SH_DR   = 4'b0100,
        TAP_EX1_DR  = 4'b0101,
        TAP_PA_DR   = 4'b0110,
        TAP_EX2_DR  = 4'b0111,
        TAP_UPD_DR  = 4'b1000,
        TAP_SEL_IR  = 4'b1001,
        TAP_CAP_IR  = 4'b1010,
        TAP_SH_IR   = 4'b1011,
        TAP_EX1_IR  = 4'b1100,
        TAP_PA_IR   = 4'b1101,
        TAP_EX2_IR  = 4'b1110,
        TAP_UPD_IR  = 4'b1111
    } sbs_tap_state_t;

    // ---------------------------------------------------------------
    // Synchronous bus controls sampled on rising clock edges while not asleep and the write buffer has room
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       chip_enable_n;
        logic       chip_select_hi;
        logic       chip_select_lo_n;
        logic       cache_addr_strobe_n;
        logic       proc_addr_strobe_n;
        logic       burst_advance_n;
        logic       all_lanes_write_n;
        logic       lane_write_gate_n;
        logic [3:0] lane_write_sel_n;
    } sbs_bus_ctl_t;

endpackage

// ===== hdl/sbs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wp;
        logic [PW:0]                 rp;
    } sbs_fifo_st_t;

    sbs_fifo_st_t st_r;
    sbs_fifo_st_t st_nxt;

    assign in_ready  = !((st_r.wp[PW] != st_r.rp[PW]) && (st_r.wp[PW-1:0] == st_r.rp[PW-1:0]));
    assign out_valid = (st_r.wp != st_r.rp);
    assign out_data  = st_r.mem[st_r.rp[PW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (in_valid && in_ready) begin
            st_nxt.mem[st_r.wp[PW-1:0]] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/sbs_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sbs_mem #(
    parameter int ADDR_W = 17,
    parameter int LANES  = 4,
    parameter int LANE_W = 9
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Write port
    input  wire logic                      wr_en,
    input  wire logic [ADDR_W-1:0]         wr_addr,
    input  wire logic [LANES-1:0]          wr_lanes,
    input  wire logic [LANES*LANE_W-1:0]   wr_data,
    // Read port
    input  wire logic                      rd_en,
    input  wire logic [ADDR_W-1:0]         rd_addr,
    output logic [LANES*LANE_W-1:0]        rd_data
);
    // ---------------------------------------------------------------
    // One array and one read register per lane.
    // ---------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] arr [2**ADDR_W];
        logic [LANE_W-1:0] rd_q;

        always_ff @(posedge clk) begin
            if (wr_en && wr_lanes[g]) begin
                arr[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rd_q <= '0;
            end else if (rd_en) begin
                rd_q <= arr[rd_addr];
            end
        end

        assign rd_data[g*LANE_W +: LANE_W] = rd_q;
    end
endmodule
`default_nettype wire

// ===== hdl/sbs_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbs_defs.svh"

module sbs_port #(
    parameter int          ADDR_W = `SBS_ADDR_W,
    parameter int          DEPTH  = `SBS_FIFO_DEPTH,
    parameter logic [31:0] IDCODE = `SBS_IDCODE
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Address and control
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              chip_enable_n,
    input  wire logic              chip_select_hi,
    input  wire logic              chip_select_lo_n,
    input  wire logic              cache_addr_strobe_n,
    input  wire logic              proc_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              burst_order_sel,
    // Write control
    input  wire logic              all_lanes_write_n,
    input  wire logic              lane_write_gate_n,
    input  wire logic [3:0]        lane_write_sel_n,
    output logic                   write_stall,
    // Data pins
    input  wire logic              output_enable_n,
    input  wire logic [31:0]       data_in,
    output logic [31:0]            data_out,
    output logic [31:0]            data_oe,
    input  wire logic [3:0]        parity_data_pins_in,
    output logic [3:0]             parity_data_pins_out,
    output logic [3:0]             parity_data_pins_oe,
    // Sleep
    input  wire logic              sleep_request,
    // Test access port
    input  wire logic              test_clk,
    input  wire logic              test_mode_sel,
    input  wire logic              test_data_in,
    input  wire logic              test_reset_n,
    output logic                   test_data_out,
    output logic                   test_data_out_oe
);
    localparam int LW = `SBS_LANE_W;
    localparam int DW = `SBS_LANES * LW;
    localparam int FW = ADDR_W + `SBS_LANES + DW;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [`SBS_PIN_N-1:0]  sync1;
        logic [`SBS_PIN_N-1:0]  sync2;
        logic [`SBS_PIN_N-1:0]  sync3;
        logic [`SBS_PIN_N-1:0]  filt;
        logic [ADDR_W-1:0]      base;
        logic [1:0]             cnt;
        logic                   active;
        logic                   drive;
        sbs_pkg::sbs_tap_state_t tap;
        logic [`SBS_IR_W-1:0]   ir;
        logic [`SBS_IR_W-1:0]   ir_sh;
        logic [`SBS_DR_W-1:0]   dr_sh;
        logic                   tdo;
        logic                   tdo_oe;
    } sbs_st_t;

    sbs_st_t             st_r;
    sbs_st_t             st_nxt;
    sbs_pkg::sbs_bus_ctl_t ctl;
    logic                run;
    logic                sel;
    logic                load;
    logic                tck_rise;
    logic                tck_fall;
    logic [3:0]          lanes;
    logic                push;
    logic [ADDR_W-1:0]   cur_addr;
    logic [DW-1:0]       wdata;
    logic [DW-1:0]       rdata;
    logic                fifo_ready;
    logic                fifo_valid;
    logic [FW-1:0]       fifo_out;
    logic                drv;

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [1:0] burst_lsb(input logic [1:0] start, input logic [1:0] cnt,
                                             input logic interleave);
        burst_lsb = interleave ? (start ^ cnt) : 2'(start + cnt);
    endfunction

    function automatic sbs_pkg::sbs_tap_state_t tap_next(input sbs_pkg::sbs_tap_state_t s,
                                                         input logic tms);
        unique case (s)
            sbs_pkg::TAP_RESET:  tap_next = tms ? sbs_pkg::TAP_RESET  : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_IDLE:   tap_next = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_SEL_DR: tap_next = tms ? sbs_pkg::TAP_SEL_IR : sbs_pkg::TAP_CAP_DR;
            sbs_pkg::TAP_CAP_DR: tap_next = tms ? sbs_pkg::TAP_EX1_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_SH_DR:  tap_next = tms ? sbs_pkg::TAP_EX1_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_EX1_DR: tap_next = tms ? sbs_pkg::TAP_UPD_DR : sbs_pkg::TAP_PA_DR;
            sbs_pkg::TAP_PA_DR:  tap_next = tms ? sbs_pkg::TAP_EX2_DR : sbs_pkg::TAP_PA_DR;
            sbs_pkg::TAP_EX2_DR: tap_next = tms ? sbs_pkg::TAP_UPD_DR : sbs_pkg::TAP_SH_DR;
            sbs_pkg::TAP_UPD_DR: tap_next = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
            sbs_pkg::TAP_SEL_IR: tap_next = tms ? sbs_pkg::TAP_RESET  : sbs_pkg::TAP_CAP_IR;
            sbs_pkg::TAP_CAP_IR: tap_next = tms ? sbs_pkg::TAP_EX1_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_SH_IR:  tap_next = tms ? sbs_pkg::TAP_EX1_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_EX1_IR: tap_next = tms ? sbs_pkg::TAP_UPD_IR : sbs_pkg::TAP_PA_IR;
            sbs_pkg::TAP_PA_IR:  tap_next = tms ? sbs_pkg::TAP_EX2_IR : sbs_pkg::TAP_PA_IR;
            sbs_pkg::TAP_EX2_IR: tap_next = tms ? sbs_pkg::TAP_UPD_IR : sbs_pkg::TAP_SH_IR;
            sbs_pkg::TAP_UPD_IR: tap_next = tms ? sbs_pkg::TAP_SEL_DR : sbs_pkg::TAP_IDLE;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    assign ctl = '{chip_enable_n, chip_select_hi, chip_select_lo_n, cache_addr_strobe_n,
                   proc_addr_strobe_n, burst_advance_n, all_lanes_write_n, lane_write_gate_n,
                   lane_write_sel_n};

    assign run  = !st_r.filt[`SBS_PIN_SLEEP] && fifo_ready;
    assign sel  = !ctl.chip_enable_n && ctl.chip_select_hi && !ctl.chip_select_lo_n;
    assign load = !ctl.cache_addr_strobe_n
                  || (!ctl.proc_addr_strobe_n && !ctl.chip_enable_n);
    assign lanes = !ctl.all_lanes_write_n ? `SBS_ALL_LANES
                 : (!ctl.lane_write_gate_n ? ~ctl.lane_write_sel_n : 4'h0);
    assign write_stall = !fifo_ready;

    for (genvar g = 0; g < `SBS_LANES; g++) begin : g_pack
        assign wdata[g*LW +: LW] = {parity_data_pins_in[g], data_in[g*8 +: 8]};
        assign data_out[g*8 +: 8]      = rdata[g*LW +: 8];
        assign parity_data_pins_out[g] = rdata[g*LW + 8];
    end

    // ---------------------------------------------------------------
    // Output drivers
    // ---------------------------------------------------------------
    assign drv = !output_enable_n && st_r.drive && !st_r.filt[`SBS_PIN_SLEEP]
                 && (&lane_write_sel_n);
    assign data_oe             = {32{drv}};
    assign parity_data_pins_oe = {4{drv}};
    assign test_data_out       = st_r.tdo;
    assign test_data_out_oe    = st_r.tdo_oe;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [`SBS_PIN_N-1:0] agree;
        logic                  tms;
        logic                  tdi;
        st_nxt   = st_r;
        agree    = ~(st_r.sync2 ^ st_r.sync3);
        tms      = st_r.filt[`SBS_PIN_TMS];
        tdi      = st_r.filt[`SBS_PIN_TDI];
        st_nxt.sync1 = {sleep_request, test_reset_n, test_data_in, test_mode_sel, test_clk};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.filt  = (agree & st_r.sync3) | (~agree & st_r.filt);
        tck_rise = st_nxt.filt[`SBS_PIN_TCK] && !st_r.filt[`SBS_PIN_TCK];
        tck_fall = !st_nxt.filt[`SBS_PIN_TCK] && st_r.filt[`SBS_PIN_TCK];

        if (run) begin
            if (load) begin
                st_nxt.base   = addr_in;
                st_nxt.cnt    = 2'h0;
                st_nxt.active = sel;
            end else if (st_r.active && !ctl.burst_advance_n) begin
                st_nxt.cnt = 2'(st_r.cnt + 2'h1);
            end
            st_nxt.drive = st_nxt.active && (lanes == 4'h0);
        end
        cur_addr = {st_nxt.base[ADDR_W-1:2], burst_lsb(st_nxt.base[1:0], st_nxt.cnt, burst_order_sel)};
        push     = run && st_nxt.active && (lanes != 4'h0);

        if (!st_r.filt[`SBS_PIN_TRST]) begin
            st_nxt.tap = sbs_pkg::TAP_RESET;
            st_nxt.ir  = `SBS_IR_IDCODE;
            st_nxt.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            st_nxt.tap = tap_next(st_r.tap, tms);
            unique case (st_r.tap)
                sbs_pkg::TAP_RESET:  st_nxt.ir    = `SBS_IR_IDCODE;
                sbs_pkg::TAP_CAP_IR: st_nxt.ir_sh = `SBS_IR_CAPTURE;
                sbs_pkg::TAP_SH_IR:  st_nxt.ir_sh = {tdi, st_r.ir_sh[`SBS_IR_W-1:1]};
                sbs_pkg::TAP_UPD_IR: st_nxt.ir    = st_r.ir_sh;
                sbs_pkg::TAP_CAP_DR: st_nxt.dr_sh = (st_r.ir == `SBS_IR_IDCODE) ? IDCODE : '0;
                sbs_pkg::TAP_SH_DR: begin
                    if (st_r.ir == `SBS_IR_IDCODE) begin
                        st_nxt.dr_sh = {tdi, st_r.dr_sh[`SBS_DR_W-1:1]};
                    end else begin
                        st_nxt.dr_sh[0] = tdi;
                    end
                end
                default: st_nxt.ir = st_r.ir;
            endcase
        end else if (tck_fall) begin
            st_nxt.tdo_oe = (st_r.tap == sbs_pkg::TAP_SH_DR) || (st_r.tap == sbs_pkg::TAP_SH_IR);
            st_nxt.tdo    = (st_r.tap == sbs_pkg::TAP_SH_IR) ? st_r.ir_sh[0] : st_r.dr_sh[0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.sync1 <= `SBS_PIN_RST;
            st_r.sync2 <= `SBS_PIN_RST;
            st_r.sync3 <= `SBS_PIN_RST;
            st_r.filt  <= `SBS_PIN_RST;
            st_r.ir    <= `SBS_IR_IDCODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Write buffer and array
    // ---------------------------------------------------------------
    sbs_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({cur_addr, lanes, wdata}),
        .out_valid (fifo_valid),
        .out_ready (!st_r.filt[`SBS_PIN_SLEEP]),
        .out_data  (fifo_out)
    );

    sbs_mem #(.ADDR_W(ADDR_W), .LANES(`SBS_LANES), .LANE_W(LW)) u_mem (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .wr_en    (fifo_valid && !st_r.filt[`SBS_PIN_SLEEP]),
        .wr_addr  (fifo_out[FW-1 -: ADDR_W]),
        .wr_lanes (fifo_out[DW +: 4]),
        .wr_data  (fifo_out[DW-1:0]),
        .rd_en    (run),
        .rd_addr  (cur_addr),
        .rd_data  (rdata)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_load_sel;
        run && load && sel;
    endsequence

    sequence s_adv;
        run && !load && !burst_advance_n;
    endsequence

    a_addr_load: assert property (run && load |=> st_r.base == $past(addr_in))
        else $error("address not loaded");
    a_proc_addr_strobe_n_gated: assert property (run && cache_addr_strobe_n && !proc_addr_strobe_n && chip_enable_n
                                   |=> $stable(st_r.base))
        else $error("processor strobe loaded while chip enable high");
    a_count_hold: assert property (run && !load && burst_advance_n |=> $stable(st_r.cnt))
        else $error("burst counter moved without advance");
    a_lane_gate: assert property (push && all_lanes_write_n
                                  |-> lanes == ~lane_write_sel_n && !lane_write_gate_n)
        else $error("lane write not gated");
    a_all_lanes: assert property (push && !all_lanes_write_n |-> lanes == 4'hf)
        else $error("global write missed a lane");
    a_lane_off: assert property (!(&lane_write_sel_n) |-> data_oe == 32'h0 && parity_data_pins_oe == 4'h0)
        else $error("drivers on during lane write");
    a_oe_float: assert property (output_enable_n |-> data_oe == 32'h0)
        else $error("drivers on with output enable high");
    a_desel_stop: assert property (run && load && !sel |=> !st_r.active ##0 data_oe == 32'h0)
        else $error("deselected load still active");
    a_four_beats: assert property (s_load_sel ##1 s_adv [*3] |=> st_r.cnt == 2'h3 && st_r.active)
        else $error("burst did not reach fourth beat");
    a_burst_wrap: assert property ((s_adv and (st_r.active && st_r.cnt == 2'h3)) |=> st_r.cnt == 2'h0)
        else $error("burst counter did not wrap");
    a_order_sel: assert property (run && !load && st_r.active && !burst_advance_n && burst_order_sel
                                  |-> cur_addr[1:0] == (st_r.base[1:0] ^ 2'(st_r.cnt + 2'h1)))
        else $error("interleaved order wrong");
    a_tdo_shift: assert property ($rose(st_r.tdo_oe)
                                  |-> st_r.tap inside {sbs_pkg::TAP_SH_DR, sbs_pkg::TAP_SH_IR})
        else $error("test output enabled outside shift");
    a_tdo_fall: assert property ($changed(st_r.tdo) |-> $past(tck_fall))
        else $error("test output changed off falling edge");
    a_trst_reset: assert property (!st_r.filt[`SBS_PIN_TRST] |=> st_r.tap == sbs_pkg::TAP_RESET)
        else $error("test reset ignored");
    a_sleep_hold: assert property (st_r.filt[`SBS_PIN_SLEEP] |-> !drv ##1 $stable(st_r.base))
        else $error("state moved in sleep");
endmodule
`default_nettype wire

// ===== sim/sbs_host.sv
`timescale 1ns/100ps
`default_nettype none
module sbs_host (
    // Bus side
    input  wire logic             clk,
    output var sbs_pkg::sbs_bus_ctl_t ctl,
    output logic [16:0]           addr,
    output logic [35:0]           din,
    output logic                  burst_order_sel
);
    // ------------
    // Bus cycles
    // ------------
    initial begin
        ctl = sbs_pkg::sbs_bus_ctl_t'(12'h5ff);
        addr = '0;
        din = '0;
        burst_order_sel = 1'b0;
    end
    // Called only between transfers.
    task automatic set_order(input logic o);
        burst_order_sel = o;
    endtask
    // Drives just after the edge; data is inverted when not writing.
    task automatic cyc(input logic [11:0] c, input logic [16:0] a, input logic [35:0] d);
        @(posedge clk);
        #1;
        ctl = sbs_pkg::sbs_bus_ctl_t'(c);
        addr = a;
        din = (c[5] & c[4]) ? ~din : d;
    endtask
endmodule
`default_nettype wire

// ===== sim/test_sync_burst_sram_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbs_defs.svh"
module test_sync_burst_sram_port;
    logic                  ref_clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  oe_n = 1'b0;
    int                    fails = 0;
    int                    checks_done = 0;
    sbs_pkg::sbs_bus_ctl_t ctl;
    logic [16:0]           addr;
    logic [35:0]           din;
    logic                  order;
    logic [31:0]           dout;
    logic [31:0]           doe;
    logic [3:0]            pout;
    logic [3:0]            poe;
    logic                  sleep = 1'b0;
    logic                  tck_pin = 1'b0;
    logic                  tms_pin = 1'b1;
    logic                  trst_n = 1'b1;
    logic                  stall;
    logic                  tdo;
    logic                  tdo_oe;
    // ------------
    // Harness
    // ------------
    always #20 ref_clk = ~ref_clk;
    sbs_host host (.clk(ref_clk), .ctl(ctl), .addr(addr), .din(din), .burst_order_sel(order));
    sbs_port dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr_in(addr), .chip_enable_n(ctl.chip_enable_n),
        .chip_select_hi(ctl.chip_select_hi), .chip_select_lo_n(ctl.chip_select_lo_n),
        .cache_addr_strobe_n(ctl.cache_addr_strobe_n), .proc_addr_strobe_n(ctl.proc_addr_strobe_n),
        .burst_advance_n(ctl.burst_advance_n), .burst_order_sel(order),
        .all_lanes_write_n(ctl.all_lanes_write_n), .lane_write_gate_n(ctl.lane_write_gate_n),
        .lane_write_sel_n(ctl.lane_write_sel_n), .write_stall(stall), .output_enable_n(oe_n),
        .data_in(din[31:0]), .data_out(dout), .data_oe(doe), .parity_data_pins_in(din[35:32]),
        .parity_data_pins_out(pout), .parity_data_pins_oe(poe), .sleep_request(sleep),
        .test_clk(tck_pin), .test_mode_sel(tms_pin), .test_data_in(1'b1), .test_reset_n(trst_n),
        .test_data_out(tdo), .test_data_out_oe(tdo_oe)
    );
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [16:0] a);
        host.cyc(12'h4ff, a, '0);
        host.cyc(12'h5ff, a, '0);
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic t_global;
        host.cyc(12'h4df, 17'h10, 36'ha_1234_5678);
        host.cyc(12'h5ff, '0, '0);
        rd(17'h10);
        chk("word", {pout, dout}, 36'ha_1234_5678);
        chk("oe", {poe, doe}, '1);
        oe_n = 1'b1;
        #1 chk("oe_off", {poe, doe}, '0);
        @(posedge ref_clk) #1 oe_n = 1'b0;
        $display("test global done");
    endtask
    task automatic t_lanes;
        host.cyc(12'h4ed, 17'h10, 36'h5_aabb_ccdd);
        #1 chk("drv_off", {poe, doe}, '0);
        host.cyc(12'h4fd, 17'h10, '0);
        host.cyc(12'h5ff, '0, '0);
        rd(17'h10);
        chk("lane", {pout, dout}, 36'h8_1234_cc78);
        $display("test lanes done");
    endtask
    task automatic t_burst;
        logic [1:0] b;
        for (int i = 0; i < 4; i++) host.cyc(12'h4df, 17'h20 + 17'(i), 36'(i + 5));
        for (int o = 0; o < 2; o++) begin
            host.cyc(12'h5ff, '0, '0);
            host.set_order(o[0]);
            host.cyc(12'h4ff, 17'h21, '0);
            for (int k = 0; k < 5; k++) begin
                host.cyc(k < 4 ? 12'h5bf : 12'h5ff, '0, '0);
                b = o[0] ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
                chk("beat", {pout, dout}, 36'(b) + 36'h5);
            end
        end
        $display("test burst done");
    endtask
    task automatic t_refuse;
        rd(17'h10);
        host.cyc(12'hd7f, 17'h20, '0);
        host.cyc(12'h5ff, 17'h20, '0);
        chk("ce_gate", {pout, dout}, 36'h8_1234_cc78);
        host.cyc(12'h57f, 17'h20, '0);
        host.cyc(12'h5ff, 17'h20, '0);
        chk("proc_load", {pout, dout}, 36'h5);
        host.cyc(12'h0ff, 17'h10, '0);
        host.cyc(12'h5bf, 17'h10, '0);
        chk("desel", {poe, doe}, '0);
        host.cyc(12'h5ff, 17'h10, '0);
        chk("desel_adv", {poe, doe}, '0);
        chk("desel_hold", {pout, dout}, 36'h8_1234_cc78);
        $display("test refuse done");
    endtask
    task automatic t_sleep;
        rd(17'h10);
        sleep = 1'b1;
        repeat (5) host.cyc(12'h5ff, '0, '0);
        host.cyc(12'h4df, 17'h10, '0);
        host.cyc(12'h5ff, '0, '0);
        chk("sleep_oe", {poe, doe}, '0);
        chk("sleep_hold", {pout, dout}, 36'h8_1234_cc78);
        chk("stall", 36'(stall), '0);
        sleep = 1'b0;
        repeat (5) host.cyc(12'h5ff, '0, '0);
        rd(17'h10);
        chk("sleep_keep", {pout, dout}, 36'h8_1234_cc78);
        $display("test sleep done");
    endtask
    task automatic tck(input logic m);
        tms_pin = m;
        repeat (5) @(posedge ref_clk);
        #1 tck_pin = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 tck_pin = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_test_port;
        logic [31:0] id;
        id = `SBS_IDCODE;
        for (int i = 0; i < 4; i++) tck(i == 1);
        for (int i = 0; i < 32; i++) begin
            chk("tdo", 36'({tdo_oe, tdo}), 36'({1'b1, id[i]}));
            tck(1'b0);
        end
        trst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 chk("trst_oe", 36'(tdo_oe), '0);
        trst_n = 1'b1;
        tck(1'b0);
        chk("trst_idle", 36'(tdo_oe), '0);
        $display("test port done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_global;
        t_lanes;
        t_burst;
        t_refuse;
        t_sleep;
        t_test_port;
        final_report;
    end
    initial begin
        #100000;
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
